// File: include/pviu_cfg.svh
`ifndef PVIU_CFG_SVH
`define PVIU_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define PVIU_ADDR_W          4
`define PVIU_OFF_CTRL_PRI    4'h0
`define PVIU_OFF_CTRL_SEC    4'h1
`define PVIU_OFF_GRP_FLAGS   4'h2
`define PVIU_OFF_IRQ_STATUS  4'h3
`define PVIU_OFF_IRQ_MASK    4'h4
`define PVIU_OFF_STACK_DEPTH 4'h5

// ****************************************************************
// Primary control fields
// ****************************************************************
`define PVIU_PRI_GEN         0
`define PVIU_PRI_EZ_EN       1
`define PVIU_PRI_EO_EN       2
`define PVIU_PRI_TZ_EN       3
`define PVIU_PRI_EZ_FL       4
`define PVIU_PRI_EO_FL       5
`define PVIU_PRI_TZ_FL       6
`define PVIU_PRI_MASK        8'h7f

// ****************************************************************
// Secondary control fields
// ****************************************************************
`define PVIU_SEC_TO_EN       0
`define PVIU_SEC_SR_EN       1
`define PVIU_SEC_GR_EN       2
`define PVIU_SEC_TO_FL       4
`define PVIU_SEC_SR_FL       5
`define PVIU_SEC_GR_FL       6
`define PVIU_SEC_MASK        8'h77

// ****************************************************************
// Vectors, group and reset values
// ****************************************************************
`define PVIU_VEC_EXT0        8'h04
`define PVIU_VEC_EXT1        8'h08
`define PVIU_VEC_TMR0        8'h0c
`define PVIU_VEC_TMR1        8'h10
`define PVIU_VEC_SER         8'h14
`define PVIU_VEC_GRP         8'h18
`define PVIU_NUM_SRC         6
`define PVIU_NUM_GRP         6
`define PVIU_RST_BYTE        8'h00
`define PVIU_STACK_DEPTH     8

`endif

// File: include/pviu_pkg.sv
package pviu_pkg;

  // Arbitration outcome, one-hot by source
  typedef logic [5:0] pviu_src_vec_t;

  // Grant sequencer states
  typedef enum logic [2:0] {
    PVIU_IDLE  = 3'b001,
    PVIU_WAIT  = 3'b010,
    PVIU_GRANT = 3'b100
  } pviu_state_t;

endpackage

// File: rtl/pviu_arbiter.sv
`timescale 1ns/100ps
`include "pviu_cfg.svh"

// Fixed-priority pick; bit 0 is the highest priority
module pviu_arbiter
  import pviu_pkg::*;
(
  // Requests
  input  wire logic [5:0] req,
  // Result
  output logic            any,
  output pviu_src_vec_t   pick,
  output logic [7:0]      vector
);

  always_comb
  begin
    pick   = '0;
    vector = 8'h00;
    any    = |req;
    if (req[0])
    begin
      pick[0] = 1'b1;
      vector  = `PVIU_VEC_EXT0;
    end
    else if (req[1])
    begin
      pick[1] = 1'b1;
      vector  = `PVIU_VEC_EXT1;
    end
    else if (req[2])
    begin
      pick[2] = 1'b1;
      vector  = `PVIU_VEC_TMR0;
    end
    else if (req[3])
    begin
      pick[3] = 1'b1;
      vector  = `PVIU_VEC_TMR1;
    end
    else if (req[4])
    begin
      pick[4] = 1'b1;
      vector  = `PVIU_VEC_SER;
    end
    else if (req[5])
    begin
      pick[5] = 1'b1;
      vector  = `PVIU_VEC_GRP;
    end
  end

endmodule

// File: rtl/pviu_flag.sv
`timescale 1ns/100ps
`include "pviu_cfg.svh"

// One request flag: hardware set beats any clear in the same cycle
module pviu_flag
  import pviu_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Controls
  input  wire logic set,
  input  wire logic wr_en,
  input  wire logic wr_val,
  input  wire logic hw_clr,
  // State
  output logic      flag
);

  typedef struct packed {
    logic f;
  } pviu_flag_st_t;

  pviu_flag_st_t s_q;
  pviu_flag_st_t s_d;

  // Next value: set wins, then write, then hardware clear
  always_comb
  begin
    s_d = s_q;
    if (hw_clr)
    begin
      s_d.f = 1'b0;
    end
    if (wr_en)
    begin
      s_d.f = wr_val;
    end
    if (set)
    begin
      s_d.f = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign flag = s_q.f;

endmodule

// File: rtl/pviu_top.sv
// Behaviour
// - Requests seen between two rising edges of the second phase clock are serviced at the later.
// - Coinciding requests grant ext line 0 (04H), ext line 1 (08H), ..., serial fifth (14H).
// - Timer 0 overflow has third priority and vector 0CH.
// - Timer 1 overflow has fourth priority and vector 10H.
// - Six grouped sources share the lowest-priority vector 18H.
// - Each grouped source has its own flag, and any of them raises the shared group flag.
// - The shared group flag is cleared by hardware when the group vector is taken.
// - Bit 0 of the secondary control register enables timer 1 requests.
// - Unimplemented control register bits ignore writes and read zero.
// - A request is serviced only while its enable is set.
// - A grant clears the global enable.
// - Requests while servicing is blocked still set and hold their flags.
// - No grant is given while the return stack is full.
// - A grant pushes the next address and loads the program counter with the vector.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/100ps
`include "pviu_cfg.svh"

module pviu_top
  import pviu_pkg::*;
#(
  parameter int NUM_GRP = `PVIU_NUM_GRP
)
(
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RST_B,
  // Register port
  input  wire logic [`PVIU_ADDR_W-1:0] ADDR,
  input  wire logic [7:0]              WDATA,
  input  wire logic                    WR,
  input  wire logic                    RD,
  output logic      [7:0]              RDATA,
  // Request sources, one-cycle event pulses
  input  wire logic                    EXT_LINE_ZERO_EV,
  input  wire logic                    EXT_LINE_ONE_EV,
  input  wire logic                    TIMER_ZERO_EV,
  input  wire logic                    TIMER_ONE_EV,
  input  wire logic                    SERIAL_EV,
  input  wire logic [NUM_GRP-1:0]      GRP_EV,
  // CPU sequencer
  input  wire logic                    SECOND_PHASE_CLOCK,
  input  wire logic                    STACK_FULL,
  output logic                         IRQ_TAKE,
  output logic                         PUSH_RET,
  output logic                         PC_LOAD,
  output logic      [7:0]              PC_VECTOR,
  // Interrupt to system
  output logic                         IRQ_OUT
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic               gen;
    logic [5:0]         en;
    logic [NUM_GRP-1:0] grp_fl;
    logic [1:0]         sts;
    logic [1:0]         msk;
    logic               ph_prev;
    logic [7:0]         vec;
    logic               take;
    logic [7:0]         rdata;
  } pviu_top_st_t;

  pviu_top_st_t s_q;
  pviu_top_st_t s_d;

  // ****************************************************************
  // Source flags
  // ****************************************************************
  logic [5:0]  flag;
  logic [5:0]  set_ev;
  logic [5:0]  wr_fl_en;
  logic [5:0]  wr_fl_val;
  logic [5:0]  hw_clr;
  logic        wr_pri;
  logic        wr_sec;
  logic        any;
  logic [5:0]  pick;
  logic [7:0]  vector;
  logic        phase_rise;
  logic        grant;

  assign wr_pri = WR && (ADDR == `PVIU_OFF_CTRL_PRI);
  assign wr_sec = WR && (ADDR == `PVIU_OFF_CTRL_SEC);

  // Group flag rises on any grouped source becoming active
  assign set_ev = {|GRP_EV, SERIAL_EV, TIMER_ONE_EV, TIMER_ZERO_EV,
                   EXT_LINE_ONE_EV, EXT_LINE_ZERO_EV};

  // Register bit of each flag; enable blocks nothing here so flags always record
  assign wr_fl_en  = {wr_sec, wr_sec, wr_sec, wr_pri, wr_pri, wr_pri};
  assign wr_fl_val = {WDATA[`PVIU_SEC_GR_FL], WDATA[`PVIU_SEC_SR_FL],
                      WDATA[`PVIU_SEC_TO_FL], WDATA[`PVIU_PRI_TZ_FL],
                      WDATA[`PVIU_PRI_EO_FL], WDATA[`PVIU_PRI_EZ_FL]};

  // Serviced flag is cleared by hardware, including the shared group flag
  assign hw_clr = grant ? pick : 6'h00;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_flag
      pviu_flag u_flag (
        .clk    (CLK),
        .rst_b  (RST_B),
        .set    (set_ev[gi]),
        .wr_en  (wr_fl_en[gi]),
        .wr_val (wr_fl_val[gi]),
        .hw_clr (hw_clr[gi]),
        .flag   (flag[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  // Sticky flags hold every request seen since the last rise, so a request that
  // arrives between two rises competes at the later one
  // Only enabled requests compete
  pviu_arbiter u_arb (
    .req    (flag & s_q.en),
    .any    (any),
    .pick   (pick),
    .vector (vector)
  );

  // Fixed priority and vectors live in the arbiter
  assign phase_rise = SECOND_PHASE_CLOCK && !s_q.ph_prev;
  // Grant on the later phase edge, only if enabled and stack has room
  assign grant = phase_rise && s_q.gen && any && !STACK_FULL;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_d         = s_q;
    s_d.ph_prev = SECOND_PHASE_CLOCK;
    s_d.take    = grant;
    s_d.rdata   = 8'h00;
    // Vector is captured at the grant and held until the next one
    if (grant)
    begin
      s_d.vec = vector;
    end
    // Software writes to enables; unused bits dropped
    if (wr_pri)
    begin
      s_d.gen   = WDATA[`PVIU_PRI_GEN];
      s_d.en[0] = WDATA[`PVIU_PRI_EZ_EN];
      s_d.en[1] = WDATA[`PVIU_PRI_EO_EN];
      s_d.en[2] = WDATA[`PVIU_PRI_TZ_EN];
    end
    if (wr_sec)
    begin
      s_d.en[3] = WDATA[`PVIU_SEC_TO_EN];
      s_d.en[4] = WDATA[`PVIU_SEC_SR_EN];
      s_d.en[5] = WDATA[`PVIU_SEC_GR_EN];
    end
    // Grant blocks nesting; hardware clear wins over a same-cycle write
    if (grant)
    begin
      s_d.gen = 1'b0;
    end
    // Individual group flags: set beats write; the grant leaves them alone
    if (WR && ADDR == `PVIU_OFF_GRP_FLAGS)
    begin
      s_d.grp_fl = WDATA[NUM_GRP-1:0];
    end
    s_d.grp_fl = s_d.grp_fl | GRP_EV;
    // Sticky status: bit 0 grant, bit 1 refused for a full stack; write one clears
    if (WR && ADDR == `PVIU_OFF_IRQ_STATUS)
    begin
      s_d.sts = s_q.sts & ~WDATA[1:0];
    end
    if (WR && ADDR == `PVIU_OFF_IRQ_MASK)
    begin
      s_d.msk = WDATA[1:0];
    end
    s_d.sts[0] = s_d.sts[0] | grant;
    s_d.sts[1] = s_d.sts[1] | (phase_rise && s_q.gen && any && STACK_FULL);
    // Read data for the next cycle
    if (RD)
    begin
      case (ADDR)
        `PVIU_OFF_CTRL_PRI:
          s_d.rdata = {1'b0, flag[2:0], s_q.en[2:0], s_q.gen} & `PVIU_PRI_MASK;
        `PVIU_OFF_CTRL_SEC:
          s_d.rdata = {1'b0, flag[5:3], 1'b0, s_q.en[5:3]} & `PVIU_SEC_MASK;
        `PVIU_OFF_GRP_FLAGS:
          s_d.rdata = 8'(s_q.grp_fl);
        `PVIU_OFF_IRQ_STATUS:
          s_d.rdata = {6'h00, s_q.sts};
        `PVIU_OFF_IRQ_MASK:
          s_d.rdata = {6'h00, s_q.msk};
        default:
          s_d.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Push and vector load are one registered pulse after the grant
  assign IRQ_TAKE  = s_q.take;
  assign PUSH_RET  = s_q.take;
  assign PC_LOAD   = s_q.take;
  assign PC_VECTOR = s_q.vec;
  assign RDATA     = s_q.rdata;
  assign IRQ_OUT   = |(s_q.sts & s_q.msk);

endmodule

// File: testbench/pviu_cpu_model.sv
`timescale 1ns/100ps

// ****************************************************************
// CPU side: phase clock and return stack
// ****************************************************************
module pviu_cpu_model
#(
  parameter int DEPTH = 2
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Stack traffic
  input  wire logic push,
  input  wire logic pop,
  // To the unit
  output logic      phase,
  output logic      full
);
  logic [1:0] cnt_q;
  int         depth_q;

  // Phase clock runs free, one rise every four system clocks
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q   <= 2'h0;
      depth_q <= 0;
    end
    else
    begin
      cnt_q   <= cnt_q + 2'h1;
      depth_q <= depth_q + int'(push) - int'(pop);
    end
  end
  assign phase = cnt_q[1];
  // Small depth so a full stack is reached quickly
  assign full = (depth_q >= DEPTH);
endmodule

// File: testbench/pviu_monitor.sv
`timescale 1ns/100ps
`include "pviu_cfg.svh"

// ****************************************************************
// Grant and register port checks
// ****************************************************************
module pviu_monitor
(
  // Clock and reset
  input wire logic                    CLK,
  input wire logic                    RST_B,
  // Register port
  input wire logic [`PVIU_ADDR_W-1:0] ADDR,
  input wire logic                    RD,
  input wire logic [7:0]              RDATA,
  // CPU sequencer
  input wire logic                    SECOND_PHASE_CLOCK,
  input wire logic                    STACK_FULL,
  input wire logic                    IRQ_TAKE,
  input wire logic                    PUSH_RET,
  input wire logic                    PC_LOAD,
  input wire logic [7:0]              PC_VECTOR
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  // Service point, and a grant that lasts exactly one cycle
  sequence s_rise;
    !SECOND_PHASE_CLOCK ##1 SECOND_PHASE_CLOCK;
  endsequence
  sequence s_pulse;
    IRQ_TAKE ##1 !IRQ_TAKE;
  endsequence

  property p_cause;
    IRQ_TAKE |-> $past(SECOND_PHASE_CLOCK) && !$past(SECOND_PHASE_CLOCK, 2);
  endproperty
  property p_full;
    s_rise ##0 STACK_FULL |=> !IRQ_TAKE;
  endproperty
  property p_one;
    IRQ_TAKE |-> s_pulse;
  endproperty
  property p_push;
    (PUSH_RET == IRQ_TAKE) && (PC_LOAD == IRQ_TAKE);
  endproperty
  property p_vec;
    IRQ_TAKE |-> PC_VECTOR[1:0] == 2'h0 && PC_VECTOR >= 8'h04 && PC_VECTOR <= 8'h18;
  endproperty
  property p_hold;
    !IRQ_TAKE |-> $stable(PC_VECTOR);
  endproperty
  property p_idle;
    !RD |=> RDATA == 8'h00;
  endproperty
  property p_sec;
    RD && ADDR == 4'h1 |=> (RDATA & 8'h88) == 8'h00;
  endproperty

  a_cause: assert property (p_cause) else $error("grant off phase rise");
  a_full: assert property (p_full) else $error("grant on full stack");
  a_one: assert property (p_one) else $error("grant pulse too long");
  a_push: assert property (p_push) else $error("push and load split");
  a_vec: assert property (p_vec) else $error("vector out of table");
  a_hold: assert property (p_hold) else $error("vector moved");
  a_idle: assert property (p_idle) else $error("read data not idle");
  a_sec: assert property (p_sec) else $error("unused bits set");
endmodule

bind pviu_top pviu_monitor u_mon
(
  .CLK                (CLK),
  .RST_B              (RST_B),
  .ADDR               (ADDR),
  .RD                 (RD),
  .RDATA              (RDATA),
  .SECOND_PHASE_CLOCK (SECOND_PHASE_CLOCK),
  .STACK_FULL         (STACK_FULL),
  .IRQ_TAKE           (IRQ_TAKE),
  .PUSH_RET           (PUSH_RET),
  .PC_LOAD            (PC_LOAD),
  .PC_VECTOR          (PC_VECTOR)
);

// File: testbench/pviu_top_tb.sv
`timescale 1ns/100ps

// ****************************************************************
// Bench
// ****************************************************************
module pviu_top_tb;
  localparam int DEPTH = 2;
  logic        clk = 0;
  logic        rst_b = 0;
  logic [3:0]  addr = 0;
  logic [7:0]  wdata = 0;
  logic        wr = 0;
  logic        rd = 0;
  logic [4:0]  ev = 0;
  logic [5:0]  grp = 0;
  logic        pop = 0;
  logic        spc, full, take, push, pld, irq;
  logic [7:0]  rdata, vec;
  logic [31:0] seed = 32'hd988;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          depth = 0;

  always #25 clk = ~clk;

  pviu_top dut (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .EXT_LINE_ZERO_EV(ev[0]), .EXT_LINE_ONE_EV(ev[1]),
    .TIMER_ZERO_EV(ev[2]), .TIMER_ONE_EV(ev[3]), .SERIAL_EV(ev[4]), .GRP_EV(grp),
    .SECOND_PHASE_CLOCK(spc), .STACK_FULL(full), .IRQ_TAKE(take), .PUSH_RET(push),
    .PC_LOAD(pld), .PC_VECTOR(vec), .IRQ_OUT(irq));
  pviu_cpu_model #(.DEPTH(DEPTH)) cpu (.clk(clk), .rst_b(rst_b), .push(push),
    .pop(pop), .phase(spc), .full(full));

  // A hang ends the run as a failure
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      end_of_test;
    end
  end

  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic end_of_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(string what, logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 check(what, rdata, e);
  endtask

  // Bounded wait; a grant is due at the first phase rise after the request
  task automatic wait_take(output bit got);
    int k;
    got = 0;
    k = 0;
    while (!got && k < 5)
    begin
      @(posedge clk);
      #1 got = (take === 1'b1);
      k++;
    end
  endtask

  task automatic pop_one;
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    depth--;
  endtask

  // Sources 0..5: ext0, ext1, timer0, timer1, serial, group
  task automatic service(logic [5:0] r, logic [5:0] e, logic m, bit do_pop);
    int k;
    bit got;
    logic [5:0] gv;
    k = 0;
    gv = r[5] ? (seed[29:24] | 6'h01) : 6'h00;
    while (k < 6 && !(r[k] && e[k]))
      k++;
    // Enables first, so a late grant of a fresh request shows up
    wr_reg(4'h4, {7'h0, m});
    wr_reg(4'h1, {5'h00, e[5:3]});
    wr_reg(4'h0, {4'h0, e[2:0], 1'b1});
    @(posedge clk);
    ev  <= r[4:0];
    grp <= gv;
    @(posedge clk);
    ev  <= 5'h0;
    grp <= 6'h0;
    wait_take(got);
    if (k == 6)
      check("no grant", 8'(got), 8'h00);
    else
    begin
      if (depth >= DEPTH)
      begin
        check("full refuse", 8'(got), 8'h00);
        rd_chk("status", 4'h3, 8'h02);
        pop_one;
        wait_take(got);
      end
      check("grant", 8'(got), 8'h01);
      check("vector", vec, 8'h04 + 8'(4 * k));
      depth++;
      r[k] = 1'b0;
      rd_chk("pri", 4'h0, {1'b0, r[2:0], e[2:0], 1'b0});
      rd_chk("sec", 4'h1, {1'b0, r[5:3], 1'b0, e[5:3]});
      check("irq out", 8'(irq), 8'(m));
    end
    rd_chk("grp", 4'h2, {2'h0, gv});
    // Software clears what the unit left behind
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h3, 8'hff);
    #1 check("irq clear", 8'(irq), 8'h00);
    if (do_pop && depth > 0)
      pop_one;
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 6; a++)
      rd_chk("reset", 4'(a), 8'h00);
    rd_chk("unmapped", 4'hf, 8'h00);
    wr_reg(4'h0, 8'hfe);
    rd_chk("pri bits", 4'h0, 8'h7e);
    wr_reg(4'h1, 8'hff);
    rd_chk("sec bits", 4'h1, 8'h77);
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h1, 8'h00);
    // Last iterations keep the stack full to force refusals
    for (int i = 0; i < 40; i++)
    begin
      seed = lfsr(seed);
      service(seed[5:0], seed[13:8], seed[16], i < 30);
      $display("test %0d done", i);
    end
    end_of_test;
  end
endmodule
